// ---- core/cfg_cycle_gen.sv ----
/*
   cfg_cycle_gen: PCI configuration cycle generator behind an APB slave.
   Software loads the target address, then touches the data register;
   the access is retried while a PCI configuration cycle runs, and the
   repeated access completes it.
   Assumes the PCI clock is far slower than i_clock and that the bench
   resolves the open pins from the output enables.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_cycle_gen (
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_pci_clk,
   input  wire logic [31:0] i_pci_ad,
   input  wire logic        i_pci_trdy_n,
   input  wire logic        i_pci_devsel_n,
   input  wire logic        i_pci_stop_n,
   output logic      [31:0] o_pci_ad,
   output logic             o_pci_ad_oe,
   output logic      [3:0]  o_pci_cbe_n,
   output logic             o_pci_frame_n,
   output logic             o_pci_irdy_n,
   output logic             o_pci_ctl_oe
);
   import cfg_gen_pkg::*;

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [31:0] addr_q, data_q;
   logic [3:0]  ctrl_q;
   pend_s       pend_q;
   logic        pending_q, done_q, abort_q;
   pci_in_s     sync1_q, sync2_q;
   logic        clk_prev_q;
   pci_state_e  state_q;
   logic [2:0]  wait_q;

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   wire   apb_acc  = i_psel & i_penable & ~o_pready;
   wire   hit_addr = i_paddr == OFS_ADDR;
   // the data register spans its word; the low bits pick the lanes
   wire   hit_data = i_paddr[7:2] == OFS_DATA[7:2];
   wire   hit_ctrl = i_paddr == OFS_CTRL;
   wire   hit_stat = i_paddr == OFS_STAT;
   wire   bme      = ctrl_q[CTRL_BME];
   pend_s cur;
   assign cur = '{dir: i_pwrite, low: i_paddr[1:0],
                  size: ctrl_q[CTRL_SIZE+:2]};
   wire   match    = done_q & (cur == pend_q);
   wire   ma_fail  = abort_q & ~ctrl_q[CTRL_MAS];
   wire   data_acc = apb_acc & hit_data & bme;
   wire   finish   = data_acc & ~pending_q & match;
   wire   launch   = data_acc & ~pending_q & ~match;
   wire   addr_wr  = apb_acc & hit_addr & i_pwrite & ~pending_q;
   wire   ctrl_wr  = apb_acc & hit_ctrl & i_pwrite;

   // error: unmapped, pci disabled, busy, retry or unhidden abort
   wire   err = ~(hit_addr | hit_data | hit_ctrl | hit_stat)
                | (hit_data & ~finish)
                | (hit_data & finish & ma_fail)
                | (hit_addr & i_pwrite & pending_q);
   wire [31:0] stat_word = {29'h0, abort_q, done_q, pending_q};
   wire [31:0] rd_word =
      hit_addr ? addr_q :
      hit_data ? (finish ? data_q : 32'h0000_0000) :
      hit_ctrl ? {28'h0, ctrl_q} :
      hit_stat ? stat_word : 32'h0000_0000;

   // ------------------------------------------------------------------
   // pci input synchronisers and clock edge
   // ------------------------------------------------------------------
   pci_in_s pin;
   assign pin = '{clk: i_pci_clk, trdy_n: i_pci_trdy_n,
                  devsel_n: i_pci_devsel_n, stop_n: i_pci_stop_n,
                  ad: i_pci_ad};
   wire pci_edge = sync2_q.clk & ~clk_prev_q;
   wire in_data  = pci_edge & (state_q == PS_DATA);
   wire pci_ok   = in_data & ~sync2_q.trdy_n & ~sync2_q.devsel_n;
   wire pci_rty  = in_data & sync2_q.trdy_n & ~sync2_q.stop_n
                   & ~sync2_q.devsel_n;
   wire pci_ma   = in_data & sync2_q.devsel_n & (wait_q == MA_LIMIT);
   wire pci_end  = pci_ok | pci_rty | pci_ma;
   wire [31:0] cfg_addr = addr_q[TYPE_BIT] ? addr_q
                                           : type0_addr(addr_q);

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         sync1_q    <= '1;
         sync2_q    <= '1;
         clk_prev_q <= 1'b1;
      end else begin
         sync1_q    <= pin;
         sync2_q    <= sync1_q;
         clk_prev_q <= sync2_q.clk;
      end
   end

   // ------------------------------------------------------------------
   // apb answer, one cycle into the access phase
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else begin
         o_pready  <= apb_acc;
         o_pslverr <= apb_acc & err;
         o_prdata  <= (apb_acc & ~i_pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------------
   // software registers and delayed-transaction bookkeeping
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         addr_q    <= ADDR_RST;
         ctrl_q    <= CTRL_RST;
         data_q    <= DATA_RST;
         pend_q    <= '0;
         pending_q <= 1'b0;
         done_q    <= 1'b0;
         abort_q   <= 1'b0;
      end else begin
         if (addr_wr)
            addr_q <= i_pwdata;
         if (ctrl_wr)
            ctrl_q <= i_pwdata[3:0];
         if (launch) begin
            pend_q    <= cur;
            pending_q <= 1'b1;
            done_q    <= 1'b0;
            abort_q   <= 1'b0;
            if (i_pwrite)
               data_q <= i_pwdata;
         end else if (finish) begin
            done_q <= 1'b0;
         end else if (pci_ok | pci_ma) begin
            pending_q <= 1'b0;
            done_q    <= 1'b1;
            abort_q   <= pci_ma;
            // aborted reads return all ones like an empty slot
            if (!pend_q.dir)
               data_q <= pci_ma ? 32'hFFFF_FFFF : sync2_q.ad;
         end
      end
   end

   // ------------------------------------------------------------------
   // pci master, stepped once per pci clock rising edge
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_q       <= PS_IDLE;
         wait_q        <= 3'h0;
         o_pci_ad      <= 32'h0000_0000;
         o_pci_ad_oe   <= 1'b0;
         o_pci_cbe_n   <= 4'hF;
         o_pci_frame_n <= 1'b1;
         o_pci_irdy_n  <= 1'b1;
         o_pci_ctl_oe  <= 1'b0;
      end else if (pci_edge) begin
         case (state_q)
            PS_IDLE: begin
               if (pending_q) begin
                  state_q       <= PS_ADDR;
                  o_pci_ad      <= cfg_addr;
                  o_pci_ad_oe   <= 1'b1;
                  o_pci_cbe_n   <= pend_q.dir ? CMD_CFG_WR : CMD_CFG_RD;
                  o_pci_frame_n <= 1'b0;
                  o_pci_ctl_oe  <= 1'b1;
               end
            end
            PS_ADDR: begin
               state_q       <= PS_DATA;
               wait_q        <= 3'h0;
               o_pci_ad      <= data_q;
               o_pci_ad_oe   <= pend_q.dir;
               o_pci_cbe_n   <= ~be_mask(pend_q.low, pend_q.size);
               o_pci_frame_n <= 1'b1;
               o_pci_irdy_n  <= 1'b0;
            end
            PS_DATA: begin
               // a target retry ends the try; idle relaunches it
               if (pci_end) begin
                  state_q      <= PS_TURN;
                  o_pci_irdy_n <= 1'b1;
                  o_pci_ad_oe  <= 1'b0;
                  o_pci_cbe_n  <= 4'hF;
               end else begin
                  wait_q <= wait_q + 3'h1;
               end
            end
            default: begin
               state_q      <= PS_IDLE;
               o_pci_ctl_oe <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);

   // address phase
   a_type1_addr: assert property (
      $fell(o_pci_frame_n) && addr_q[TYPE_BIT] |-> o_pci_ad == addr_q)
      else $error("type 1 address phase differs from address register");
   a_type0_dev: assert property (
      $fell(o_pci_frame_n) && !addr_q[TYPE_BIT]
      |-> $onehot(o_pci_ad[31:16]) && o_pci_ad[16 + addr_q[DEV_LSB+:4]])
      else $error("type 0 device line wrong");
   a_type0_low: assert property (
      $fell(o_pci_frame_n) && !addr_q[TYPE_BIT]
      |-> o_pci_ad[15:0] == {5'h00, addr_q[FUNC_LSB+:3],
                             addr_q[REG_LSB+:6], 2'h0})
      else $error("type 0 low address lines wrong");
   a_ctl_owned: assert property (
      !o_pci_frame_n || !o_pci_irdy_n |-> o_pci_ctl_oe)
      else $error("control lines asserted while released");

   // apb side of the delayed transaction
   a_launch_retry: assert property (
      launch |=> o_pready && o_pslverr && pending_q
                 ##[1:200] $fell(o_pci_frame_n))
      else $error("data access not retried and launched");
   a_busy_retry: assert property (
      apb_acc && hit_data && pending_q |=> o_pready && o_pslverr)
      else $error("access during outstanding cycle not retried");
   a_pend_hold: assert property (
      pending_q && !pci_ok && !pci_ma |=> pending_q)
      else $error("pending cycle dropped before its pci end");
   a_pend_latch: assert property (
      launch |=> pend_q == $past(cur))
      else $error("pending access attributes not latched");
   a_read_done: assert property (
      finish && !i_pwrite |=> o_pready && o_prdata == data_q && !done_q)
      else $error("matching read not completed with data");
   a_write_done: assert property (
      apb_acc && hit_data && i_pwrite && !(done_q && match) |=> o_pslverr)
      else $error("write completed before the pci write");
   a_abort_hide: assert property (
      finish && abort_q && ctrl_q[CTRL_MAS] |=> o_pready && !o_pslverr)
      else $error("master abort not reported as success");
   a_abort_shown: assert property (
      finish && ma_fail |=> o_pready && o_pslverr)
      else $error("unhidden master abort reported as success");

   // pci data phase
   a_byte_en: assert property (
      $fell(o_pci_irdy_n)
      |-> o_pci_cbe_n == ~be_mask(pend_q.low, pend_q.size))
      else $error("byte enables do not follow address and size");
   a_write_data: assert property (
      $fell(o_pci_irdy_n) && pend_q.dir
      |-> o_pci_ad_oe && o_pci_ad == data_q)
      else $error("write data not driven in data phase");
   a_read_capt: assert property (
      pci_ok && !pend_q.dir |=> data_q == $past(sync2_q.ad) && done_q)
      else $error("read data not captured");
   a_abort_ones: assert property (
      pci_ma && !pend_q.dir |=> data_q == 32'hFFFF_FFFF && abort_q)
      else $error("aborted read did not return all ones");

   c_read:  cover property (finish && !i_pwrite && !abort_q);
   c_write: cover property (finish && i_pwrite);
   c_abort: cover property (pci_ma);
   c_retry: cover property (pci_rty ##[1:400] pci_ok);
   c_type1: cover property ($fell(o_pci_frame_n) && addr_q[TYPE_BIT]);
endmodule
`default_nettype wire

// ---- include/cfg_gen_pkg.sv ----
/*
   cfg_gen_pkg: register map, field positions, reset values, PCI
   command codes and shared helpers of the configuration cycle
   generator.
   Assumes a 32-bit APB register bus and a 32-bit multiplexed PCI bus.
*/
`default_nettype none
package cfg_gen_pkg;
   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0]  OFS_ADDR  = 8'h00;
   localparam logic [7:0]  OFS_DATA  = 8'h04;
   localparam logic [7:0]  OFS_CTRL  = 8'h08;
   localparam logic [7:0]  OFS_STAT  = 8'h0C;
   localparam logic [31:0] ADDR_RST  = 32'h0000_0000;
   localparam logic [31:0] DATA_RST  = 32'h0000_0000;
   localparam logic [3:0]  CTRL_RST  = 4'h0;
   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int TYPE_BIT   = 0;
   localparam int REG_LSB    = 2;
   localparam int FUNC_LSB   = 8;
   localparam int DEV_LSB    = 11;
   localparam int CTRL_MAS   = 0;
   localparam int CTRL_BME   = 1;
   localparam int CTRL_SIZE  = 2;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_DONE  = 1;
   localparam int STAT_ABORT = 2;
   // ------------------------------------------------------------------
   // codes and counts
   // ------------------------------------------------------------------
   localparam logic [1:0] SIZE_WORD  = 2'h0;
   localparam logic [1:0] SIZE_BYTE  = 2'h1;
   localparam logic [1:0] SIZE_HALF  = 2'h2;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   // pci clocks without devsel before a master abort
   localparam logic [2:0] MA_LIMIT   = 3'h5;

   typedef struct packed {
      logic       dir;
      logic [1:0] low;
      logic [1:0] size;
   } pend_s;

   typedef struct packed {
      logic        clk;
      logic        trdy_n;
      logic        devsel_n;
      logic        stop_n;
      logic [31:0] ad;
   } pci_in_s;

   typedef enum logic [1:0] {PS_IDLE, PS_ADDR, PS_DATA, PS_TURN} pci_state_e;

   // lanes beyond lane 3 are dropped, as on a 32-bit slave
   function automatic logic [3:0] be_mask(input logic [1:0] low,
                                          input logic [1:0] size);
      logic [3:0] m;
      m = 4'h7;
      case (size)
         SIZE_BYTE: m = 4'h1;
         SIZE_HALF: m = 4'h3;
         SIZE_WORD: m = 4'hF;
         default:   m = 4'h7;
      endcase
      return 4'(m << low);
   endfunction

   function automatic logic [31:0] type0_addr(input logic [31:0] a);
      return {16'(16'h0001 << a[DEV_LSB+:4]), 5'h00, a[FUNC_LSB+:3],
              a[REG_LSB+:6], 2'h0};
   endfunction
endpackage
`default_nettype wire

// ---- tb/pci_target_model.sv ----
/*
   pci_target_model: pci target that answers configuration cycles.
   Assumes a free-running pci clock and pull-ups on the control lines.
*/
`timescale 1ns/1ps
`default_nettype none
module pci_target_model (
   input  wire logic        i_pci_clk,
   input  wire logic [31:0] i_ad,
   input  wire logic        i_ad_oe,
   input  wire logic [3:0]  i_cbe_n,
   input  wire logic        i_frame_n,
   input  wire logic        i_irdy_n,
   input  wire logic        i_ctl_oe,
   input  wire logic        i_abort,
   input  wire logic [1:0]  i_waits,
   input  wire logic [31:0] i_rdata,
   input  wire logic        i_retry,
   output logic      [31:0] o_ad,
   output logic             o_trdy_n,
   output logic             o_devsel_n,
   output logic             o_stop_n,
   output logic      [31:0] o_addr,
   output logic      [31:0] o_wdata,
   output logic      [3:0]  o_cmd,
   output logic      [3:0]  o_be,
   output logic      [7:0]  o_count
);
   // ---------------------------------------------------------------
   // resolved lines
   // ---------------------------------------------------------------
   logic       act_q   = 1'b0;
   logic       drv_q   = 1'b0;
   logic       flip_q  = 1'b0;
   logic       tried_q = 1'b0;
   logic [1:0] wait_q  = 2'h0;
   wire        frame_n = i_ctl_oe ? i_frame_n : 1'b1;
   wire        irdy_n  = i_ctl_oe ? i_irdy_n : 1'b1;
   // undriven ad toggles so a stale value never passes for data
   assign o_ad = i_ad_oe ? i_ad : drv_q ? i_rdata : {32{flip_q}};
   initial begin
      o_trdy_n   = 1'b1;
      o_devsel_n = 1'b1;
      o_stop_n   = 1'b1;
      o_count    = 8'h00;
   end
   // the master reacts to trdy within the same pci clock, so the word
   // is taken on the edge that lowers trdy, while irdy is still low
   always @(posedge i_pci_clk) begin
      flip_q <= ~flip_q;
      if (!act_q && !frame_n) begin
         act_q      <= 1'b1;
         o_addr     <= o_ad;
         o_cmd      <= i_cbe_n;
         wait_q     <= i_waits;
         o_devsel_n <= i_abort;
      end else if (act_q && o_devsel_n) begin
         act_q <= !(frame_n && irdy_n);
      end else if (act_q && !(o_trdy_n && o_stop_n)) begin
         o_trdy_n   <= 1'b1;
         o_stop_n   <= 1'b1;
         o_devsel_n <= 1'b1;
         drv_q      <= 1'b0;
         act_q      <= 1'b0;
      end else if (act_q && wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else if (act_q && i_retry && !tried_q) begin
         // one target retry per access; the master must reissue it
         o_stop_n <= 1'b0;
         tried_q  <= 1'b1;
      end else if (act_q && !irdy_n) begin
         o_trdy_n <= 1'b0;
         drv_q    <= (o_cmd == 4'hA);
         o_wdata  <= o_ad;
         o_be     <= ~i_cbe_n;
         o_count  <= o_count + 8'h01;
         tried_q  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
   testbench: apb master, pci target model, random and corner accesses.
   Assumes cfg_gen_pkg and the target model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cfg_gen_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and wires
   // ---------------------------------------------------------------
   logic        i_clock = 1'b0;
   logic        i_srst  = 1'b1;
   logic        pci_clk = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic        abort   = 1'b0;
   logic [1:0]  waits   = 2'h0;
   logic [31:0] rdata   = 32'h0000_0000;
   logic        retry   = 1'b0;
   logic [31:0] seed    = 32'h0000_0014;
   int          miscompares = 0;
   int          check_count = 0;
   logic [31:0] prdata, ad_o, ad_i, t_addr, t_wdata;
   logic [3:0]  cbe_n, t_cmd, t_be;
   logic [7:0]  t_count;
   logic        pready, pslverr, ad_oe, frame_n, irdy_n, ctl_oe;
   logic        trdy_n, devsel_n, stop_n;
   cfg_cycle_gen i_cfg_cycle_gen (.i_clock(i_clock), .i_srst(i_srst),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_pci_clk(pci_clk),
      .i_pci_ad(ad_i), .i_pci_trdy_n(trdy_n), .i_pci_devsel_n(devsel_n),
      .i_pci_stop_n(stop_n), .o_pci_ad(ad_o), .o_pci_ad_oe(ad_oe),
      .o_pci_cbe_n(cbe_n), .o_pci_frame_n(frame_n),
      .o_pci_irdy_n(irdy_n), .o_pci_ctl_oe(ctl_oe));
   pci_target_model u_target (.i_pci_clk(pci_clk), .i_ad(ad_o),
      .i_ad_oe(ad_oe), .i_cbe_n(cbe_n), .i_frame_n(frame_n),
      .i_irdy_n(irdy_n), .i_ctl_oe(ctl_oe), .i_abort(abort),
      .i_waits(waits), .i_rdata(rdata), .i_retry(retry),
      .o_ad(ad_i), .o_trdy_n(trdy_n),
      .o_devsel_n(devsel_n), .o_stop_n(stop_n), .o_addr(t_addr),
      .o_wdata(t_wdata), .o_cmd(t_cmd), .o_be(t_be), .o_count(t_count));
   initial begin
      forever #2 i_clock = ~i_clock;
   end
   initial begin
      #1.3;
      forever #62.5 pci_clk = ~pci_clk;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] exp_addr(input logic [31:0] a);
      if (a[0]) return a;
      return {16'h0001 << a[14:11], 5'h00, a[10:2], 2'h0};
   endfunction
   // lanes pushed past lane 3 fall away, as on a 32-bit target
   function automatic logic [3:0] exp_be(input logic [1:0] lo,
                                         input logic [1:0] sz);
      logic [3:0] m;
      m = (sz == 2'h0) ? 4'hF : (4'h1 << sz) - 4'h1;
      return m << lo;
   endfunction
   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] ex);
      check_count++;
      if (got !== ex) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      n = 0;
      @(posedge i_clock);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      do begin
         @(posedge i_clock);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n == 40) miscompares++;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // one delayed transaction: launch, retry while pending, completion
   task automatic xact(input logic ab, input logic mas);
      logic [31:0] a, d, q, r;
      logic [7:0]  da, n0;
      logic        e, wr;
      int          n;
      a = rnd();
      d = rnd();
      r = rnd();
      wr = r[0];
      da = OFS_DATA | {6'h00, r[2:1]};
      abort <= ab;
      waits <= r[6:5];
      retry <= r[7];
      rdata <= d;
      n0 = t_count;
      apb(1'b1, OFS_ADDR, a, q, e);
      apb(1'b1, OFS_CTRL, {28'h000_0000, r[4:3], 1'b1, mas}, q, e);
      apb(wr, da, d, q, e);
      chk("launch retry", 32'(e), 32'h1);
      apb(wr, da, d, q, e);
      chk("pending retry", 32'(e), 32'h1);
      n = 0;
      do begin
         apb(1'b0, OFS_STAT, 32'h0, q, e);
         n++;
      end while (q[STAT_BUSY] !== 1'b0 && n < 300);
      chk("busy cleared", 32'(q[STAT_BUSY]), 32'h0);
      apb(wr, da, d, q, e);
      chk("completion error", 32'(e), 32'(ab & ~mas));
      if (ab) begin
         if (!wr) chk("abort data", q, 32'hFFFF_FFFF);
         return;
      end
      chk("pci count", 32'(t_count), 32'(n0 + 8'h01));
      chk("address phase", t_addr, exp_addr(a));
      chk("command", 32'(t_cmd), wr ? 32'hB : 32'hA);
      chk("byte enables", 32'(t_be), 32'(exp_be(r[2:1], r[4:3])));
      chk("data", wr ? t_wdata : q, d);
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic        e;
      repeat (12) @(posedge i_clock);
      i_srst <= 1'b0;
      apb(1'b0, OFS_ADDR, 32'h0, q, e);
      chk("address reset", q, ADDR_RST);
      apb(1'b0, 8'h10, 32'h0, q, e);
      chk("unmapped error", 32'(e), 32'h1);
      apb(1'b0, OFS_DATA, 32'h0, q, e);
      chk("disabled error", 32'(e), 32'h1);
      repeat (400) @(posedge i_clock);
      chk("disabled idle", 32'(t_count), 32'h0);
      for (int i = 0; i < 16; i++) xact(1'b0, seed[7]);
      xact(1'b1, 1'b1);
      xact(1'b1, 1'b0);
      results();
   end
   // the whole run needs some 5k clocks
   initial begin
      #100000;
      miscompares++;
      results();
   end
endmodule
`default_nettype wire
